// File: rtl/rvp_top.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
module rvp_top #(
  parameter int MODE_WAIT = rvp_pkg::MODE_WAIT_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        chip_clear_pin_n,
  input  wire logic        boot_mode_pin,
  input  wire logic [4:0]  irq_pin,
  input  wire logic [7:0]  wake_pin_n,
  // peripheral requests, already flagged and enabled
  input  wire logic [19:0] periph_req,
  // cpu core
  input  wire logic        core_boundary,
  input  wire logic        core_mask_set,
  input  wire logic        core_mask_clr,
  output logic             cpu_hold,
  output logic             periph_rst_n,
  output logic             cond_imask,
  output logic             pc_load,
  output logic      [15:0] pc_value,
  output logic             int_ack,
  output logic      [4:0]  int_vec,
  // vector table read port, data valid while vec_rd is high
  output logic             vec_rd,
  output logic      [15:0] vec_addr,
  input  wire logic [7:0]  vec_rdata
);

  typedef struct packed {
    rvp_pkg::rvp_state_e state;
    logic [13:0] cnt;
    logic [14:0] s1;
    logic [14:0] s2;
    logic [12:0] prev;
    logic [4:0]  edge_sel;
    logic [12:0] enable;
    logic [12:0] flags;
    logic        imask;
    logic        first;
    logic        hold;
    logic        prst_n;
    logic [7:0]  hi;
    logic [15:0] pc;
    logic        pc_load;
    logic        rd;
    logic [15:0] addr;
    logic        ack;
    logic [4:0]  vec;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rvp_regs_s;

  rvp_regs_s r_q;
  rvp_regs_s r_d;

  rvp_prio_if pif ();

  rvp_prio u_prio (
    .pif (pif)
  );

  logic [12:0] ext_ev;
  logic        clr_s;
  logic        mode_s;
  logic        accept;
  logic        setup;
  logic        wr_acc;

  assign clr_s  = r_q.s2[rvp_pkg::SY_CLEAR];
  assign mode_s = r_q.s2[rvp_pkg::SY_MODE];
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && r_q.pready && pwrite;

  // edge detection per external line
  for (genvar i = 0; i < rvp_pkg::N_IRQ; i++) begin : g_irq
    logic cur;
    logic old;
    assign cur = r_q.s2[rvp_pkg::SY_IRQ + i];
    assign old = r_q.prev[rvp_pkg::EXT_IRQ + i];
    assign ext_ev[rvp_pkg::EXT_IRQ + i] = r_q.edge_sel[i] ? (cur && !old)
                                                          : (!cur && old);
  end
  for (genvar i = 0; i < rvp_pkg::N_WAKE; i++) begin : g_wake
    assign ext_ev[rvp_pkg::EXT_WAKE + i] = !r_q.s2[rvp_pkg::SY_WAKE + i] &&
                                           r_q.prev[rvp_pkg::EXT_WAKE + i];
  end

  // request lines in priority order
  always_comb begin
    logic [12:0] pend;
    pend = r_q.flags & r_q.enable;
    pif.req = '0;
    pif.req[rvp_pkg::LN_IRQ0 +: 5] = pend[rvp_pkg::EXT_IRQ +: 5];
    pif.req[rvp_pkg::LN_WAKE] = |pend[rvp_pkg::EXT_WAKE +: 8];
    pif.req[rvp_pkg::LN_SER1] = periph_req[rvp_pkg::INT_SER1];
    pif.req[rvp_pkg::LN_TA]   = periph_req[rvp_pkg::INT_TA];
    pif.req[rvp_pkg::LN_TB]   = periph_req[rvp_pkg::INT_TB];
    pif.req[rvp_pkg::LN_TC]   = periph_req[rvp_pkg::INT_TC];
    pif.req[rvp_pkg::LN_FL]   = |periph_req[rvp_pkg::INT_FL +: 2];
    pif.req[rvp_pkg::LN_FH]   = |periph_req[rvp_pkg::INT_FH +: 2];
    pif.req[rvp_pkg::LN_TG]   = |periph_req[rvp_pkg::INT_TG +: 2];
    pif.req[rvp_pkg::LN_SER2] = |periph_req[rvp_pkg::INT_SER2 +: 2];
    pif.req[rvp_pkg::LN_SER3] = |periph_req[rvp_pkg::INT_SER3 +: 6];
    pif.req[rvp_pkg::LN_AD]   = periph_req[rvp_pkg::INT_AD];
    pif.req[rvp_pkg::LN_DT]   = periph_req[rvp_pkg::INT_DT];
  end

  // accept only unmasked, after first instruction, at a boundary
  assign accept = (r_q.state == rvp_pkg::ST_RUN) && pif.hit && !r_q.imask
                  && !r_q.first && core_boundary;

  always_comb begin
    r_d = r_q;
    r_d.s1 = {wake_pin_n, irq_pin, boot_mode_pin, chip_clear_pin_n};
    r_d.s2 = r_q.s1;
    r_d.prev = {r_q.s2[rvp_pkg::SY_WAKE +: 8], r_q.s2[rvp_pkg::SY_IRQ +: 5]};
    r_d.pc_load = 1'b0;
    r_d.ack = 1'b0;
    r_d.rd = 1'b0;
    r_d.pready = setup;
    r_d.pslverr = 1'b0;

    // apb: read data and error prepared in the setup cycle
    if (setup) begin
      case (paddr)
        rvp_pkg::REG_EDGE_SEL: r_d.prdata = {27'h0000000, r_q.edge_sel};
        rvp_pkg::REG_ENABLE:   r_d.prdata = {19'h00000, r_q.enable};
        rvp_pkg::REG_FLAGS:    r_d.prdata = {19'h00000, r_q.flags};
        rvp_pkg::REG_STATUS:   r_d.prdata = {22'h000000, r_q.vec, r_q.hold, r_q.imask,
                                             r_q.state};
        default: begin
          r_d.prdata = 32'h00000000;
          r_d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        rvp_pkg::REG_EDGE_SEL: r_d.edge_sel = pwdata[4:0];
        rvp_pkg::REG_ENABLE:   r_d.enable = pwdata[12:0];
        rvp_pkg::REG_FLAGS:    r_d.flags = r_q.flags & ~pwdata[12:0];
        default: ;
      endcase
    end
    // flags set regardless of the mask; set beats a same-cycle clear
    if (r_q.state != rvp_pkg::ST_HOLD) begin
      r_d.flags = r_d.flags | ext_ev;
    end

    // core updates to the mask bit, set wins
    if (r_q.state == rvp_pkg::ST_RUN) begin
      if (core_mask_set) begin
        r_d.imask = 1'b1;
      end else if (core_mask_clr) begin
        r_d.imask = 1'b0;
      end
      if (core_boundary) begin
        r_d.first = 1'b0;
      end
    end

    case (r_q.state)
      rvp_pkg::ST_HOLD: begin
        if (clr_s) begin
          r_d.state = mode_s ? rvp_pkg::ST_INIT : rvp_pkg::ST_WAIT_MODE;
        end
      end
      rvp_pkg::ST_WAIT_MODE: begin
        if (mode_s) begin
          r_d.state = rvp_pkg::ST_COUNT;
          r_d.cnt = 14'h0000;
        end
      end
      rvp_pkg::ST_COUNT: begin
        if (r_q.cnt == 14'(MODE_WAIT - 1)) begin
          r_d.state = rvp_pkg::ST_INIT;
        end else begin
          r_d.cnt = r_q.cnt + 14'h0001;
        end
      end
      rvp_pkg::ST_INIT: begin
        r_d.imask = 1'b1;
        r_d.first = 1'b1;
        r_d.prst_n = 1'b1;
        r_d.rd = 1'b1;
        r_d.addr = {10'h000, rvp_pkg::VEC_RESET, 1'b0};
        r_d.vec = rvp_pkg::VEC_RESET;
        r_d.state = rvp_pkg::ST_FETCH_HI;
      end
      rvp_pkg::ST_FETCH_HI: begin
        r_d.hi = vec_rdata;
        r_d.rd = 1'b1;
        r_d.addr = r_q.addr + 16'h0001;
        r_d.state = rvp_pkg::ST_FETCH_LO;
      end
      rvp_pkg::ST_FETCH_LO: begin
        r_d.pc = {r_q.hi, vec_rdata};
        r_d.pc_load = 1'b1;
        r_d.hold = 1'b0;
        r_d.state = rvp_pkg::ST_RUN;
      end
      rvp_pkg::ST_RUN: begin
        if (accept) begin
          r_d.imask = 1'b1;
          r_d.ack = 1'b1;
          r_d.vec = pif.vec;
          r_d.rd = 1'b1;
          r_d.addr = {10'h000, pif.vec, 1'b0};
          r_d.state = rvp_pkg::ST_FETCH_HI;
        end
      end
      default: r_d.state = rvp_pkg::ST_HOLD;
    endcase

    // chip clear overrides the state, core controls and writable registers; apb reads still answer
    if (!clr_s) begin
      r_d.state = rvp_pkg::ST_HOLD;
      r_d.hold = 1'b1;
      r_d.prst_n = 1'b0;
      r_d.imask = 1'b1;
      r_d.rd = 1'b0;
      r_d.ack = 1'b0;
      r_d.pc_load = 1'b0;
      r_d.edge_sel = rvp_pkg::EDGE_SEL_RST;
      r_d.enable = rvp_pkg::ENABLE_RST;
      r_d.flags = rvp_pkg::FLAGS_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '{state:    rvp_pkg::ST_HOLD,
               cnt:      14'h0000,
               s1:       15'h0000,
               s2:       15'h0000,
               prev:     13'h0000,
               edge_sel: rvp_pkg::EDGE_SEL_RST,
               enable:   rvp_pkg::ENABLE_RST,
               flags:    rvp_pkg::FLAGS_RST,
               imask:    1'b1,
               first:    1'b1,
               hold:     1'b1,
               prst_n:   1'b0,
               hi:       8'h00,
               pc:       16'h0000,
               pc_load:  1'b0,
               rd:       1'b0,
               addr:     16'h0000,
               ack:      1'b0,
               vec:      5'h00,
               prdata:   32'h00000000,
               pready:   1'b0,
               pslverr:  1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata       = r_q.prdata;
  assign pready       = r_q.pready;
  assign pslverr      = r_q.pslverr;
  assign cpu_hold     = r_q.hold;
  assign periph_rst_n = r_q.prst_n;
  assign cond_imask   = r_q.imask;
  assign pc_load      = r_q.pc_load;
  assign pc_value     = r_q.pc;
  assign int_ack      = r_q.ack;
  assign int_vec      = r_q.vec;
  assign vec_rd       = r_q.rd;
  assign vec_addr     = r_q.addr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_clear_halts: assert property (!clr_s |=> cpu_hold && !periph_rst_n &&
                                  r_q.state == rvp_pkg::ST_HOLD)
    else $error("chip clear did not halt");
  a_fast_release: assert property ((r_q.state == rvp_pkg::ST_HOLD && clr_s && mode_s)
                                   |=> r_q.state == rvp_pkg::ST_INIT ##1 vec_rd)
    else $error("boot-mode high release not immediate");
  a_slow_release: assert property ((r_q.state == rvp_pkg::ST_COUNT &&
                                    $past(r_q.state) == rvp_pkg::ST_WAIT_MODE)
                                   |-> r_q.cnt == 14'h0000 && cpu_hold)
    else $error("count did not start from zero");
  a_count_length: assert property ((r_q.state == rvp_pkg::ST_INIT &&
                                    $past(r_q.state) == rvp_pkg::ST_COUNT)
                                   |-> $past(r_q.cnt) == 14'(MODE_WAIT - 1))
    else $error("release wait length wrong");
  a_init_mask: assert property ((r_q.state == rvp_pkg::ST_INIT) |=>
                                cond_imask && periph_rst_n && r_q.first)
    else $error("reset handling did not set mask");
  a_reset_vector: assert property ((r_q.state == rvp_pkg::ST_INIT) |=>
                                   vec_addr == 16'h0000 ##1 vec_addr == 16'h0001 ##1 pc_load)
    else $error("reset vector fetch wrong");
  a_no_reserved: assert property (vec_rd |-> !(vec_addr >= rvp_pkg::RSV_LO &&
                                  vec_addr <= rvp_pkg::RSV_HI))
    else $error("reserved vector fetched");
  a_word_order: assert property ((r_q.state == rvp_pkg::ST_FETCH_LO) |=>
                                 pc_value == {$past(r_q.hi), $past(vec_rdata)} && pc_load)
    else $error("vector word order wrong");
  a_mask_refuse: assert property (cond_imask |=> !int_ack)
    else $error("interrupt accepted while masked");
  a_first_instr: assert property (pc_load && r_q.vec == rvp_pkg::VEC_RESET |->
                                  r_q.first && cond_imask)
    else $error("interrupt possible before first instruction");
  a_flag_set: assert property ((r_q.state == rvp_pkg::ST_RUN && clr_s &&
                                ext_ev != 13'h0000)
                               |=> (r_q.flags & $past(ext_ev)) == $past(ext_ev))
    else $error("edge flag not set");
  a_wake_shared: assert property ((accept && pif.vec == rvp_pkg::VEC_WAKE) |->
                                  pif.req[rvp_pkg::LN_WAKE] && pif.req[4:0] == 5'h00)
    else $error("wake vector chosen wrongly");
  a_top_wins: assert property ((accept && pif.req[0]) |=> int_vec == rvp_pkg::VEC_FIRST)
    else $error("highest priority not taken");
  a_ser3_group: assert property ((accept && pif.req[13:0] == 14'h0000 &&
                                  pif.req[rvp_pkg::LN_SER3]) |-> pif.vec == rvp_pkg::VEC_SER3)
    else $error("serial three vector wrong");
  a_dt_lowest: assert property ((accept && pif.vec == rvp_pkg::VEC_DT) |->
                                pif.req[15:0] == 16'h0000)
    else $error("direct transfer not lowest");
  a_boundary: assert property (int_ack |-> $past(core_boundary))
    else $error("interrupt taken off a boundary");

endmodule // rvp_top

// File: rtl/rvp_pkg.sv
package rvp_pkg;

  // register map, byte addresses on the 32-bit bus
  localparam logic [7:0] REG_EDGE_SEL = 8'h00;
  localparam logic [7:0] REG_ENABLE   = 8'h04;
  localparam logic [7:0] REG_FLAGS    = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;

  // reset values
  localparam logic [4:0]  EDGE_SEL_RST = 5'h00;
  localparam logic [12:0] ENABLE_RST   = 13'h0000;
  localparam logic [12:0] FLAGS_RST    = 13'h0000;

  // source counts
  localparam int N_IRQ   = 5;
  localparam int N_WAKE  = 8;
  localparam int N_EXT   = 13;
  localparam int N_INT   = 20;
  localparam int N_LINES = 17;
  localparam int N_SYNC  = 15;

  // synchroniser bit positions
  localparam int SY_CLEAR = 0;
  localparam int SY_MODE  = 1;
  localparam int SY_IRQ   = 2;
  localparam int SY_WAKE  = 7;

  // external flag / enable positions
  localparam int EXT_IRQ  = 0;
  localparam int EXT_WAKE = 5;

  // internal source positions on the peripheral request bus
  localparam int INT_SER1  = 0;
  localparam int INT_TA    = 1;
  localparam int INT_TB    = 2;
  localparam int INT_TC    = 3;
  localparam int INT_FL    = 4;
  localparam int INT_FH    = 6;
  localparam int INT_TG    = 8;
  localparam int INT_SER2  = 10;
  localparam int INT_SER3  = 12;
  localparam int INT_AD    = 18;
  localparam int INT_DT    = 19;

  // request line positions; line k is vector VEC_FIRST + k
  localparam int LN_IRQ0 = 0;
  localparam int LN_WAKE = 5;
  localparam int LN_SER1 = 6;
  localparam int LN_TA   = 7;
  localparam int LN_TB   = 8;
  localparam int LN_TC   = 9;
  localparam int LN_FL   = 10;
  localparam int LN_FH   = 11;
  localparam int LN_TG   = 12;
  localparam int LN_SER2 = 13;
  localparam int LN_SER3 = 14;
  localparam int LN_AD   = 15;
  localparam int LN_DT   = 16;

  // vectors
  localparam logic [4:0]  VEC_RESET = 5'h00;
  localparam logic [4:0]  VEC_FIRST = 5'h04;
  localparam logic [4:0]  VEC_WAKE  = 5'h09;
  localparam logic [4:0]  VEC_SER3  = 5'h12;
  localparam logic [4:0]  VEC_DT    = 5'h14;
  localparam logic [15:0] RSV_LO    = 16'h0002;
  localparam logic [15:0] RSV_HI    = 16'h0007;

  // cycles from boot-mode rise to reset release
  localparam int MODE_WAIT_CYC = 8192;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_WAIT_MODE,
    ST_COUNT,
    ST_INIT,
    ST_FETCH_HI,
    ST_FETCH_LO,
    ST_RUN
  } rvp_state_e;

endpackage

// File: rtl/rvp_prio_if.sv
interface rvp_prio_if;
  logic [16:0] req;
  logic        hit;
  logic [4:0]  vec;
  modport src (output req, input hit, input vec);
  modport enc (input req, output hit, output vec);
endinterface

// File: rtl/rvp_prio.sv
module rvp_prio (
  // request lines in, winner out
  rvp_prio_if.enc pif
);

  // lowest line index wins: fixed descending priority
  always_comb begin
    pif.hit = 1'b0;
    pif.vec = rvp_pkg::VEC_RESET;
    for (int i = rvp_pkg::N_LINES - 1; i >= 0; i--) begin
      if (pif.req[i]) begin
        pif.hit = 1'b1;
        pif.vec = rvp_pkg::VEC_FIRST + 5'(i);
      end
    end
  end

endmodule // rvp_prio

// File: verification/rvp_core_model.sv
module rvp_core_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // core side of the block
  input  wire logic        cpu_hold,
  input  wire logic        pc_load,
  output logic             core_boundary,
  // vector table port
  input  wire logic        vec_rd,
  input  wire logic [15:0] vec_addr,
  output logic      [7:0]  vec_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] step_q;
  logic [7:0] last_q;

  // table byte is its address folded with a constant; idle shows the inverse
  always_comb begin
    vec_rdata = vec_rd ? (vec_addr[7:0] ^ 8'hA5) : ~last_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 8'h00;
    end else if (vec_rd) begin
      last_q <= vec_rdata;
    end
  end

  // one instruction ends every fourth cycle, counted from pc_load or hold release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 2'h0;
    end else if (pc_load || cpu_hold) begin
      step_q <= 2'h0;
    end else begin
      step_q <= step_q + 2'h1;
    end
  end

  assign core_boundary = (step_q == 2'h3) && !cpu_hold;

endmodule // rvp_core_model

// File: verification/rvp_top_tb.sv
module rvp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MW = 16;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chip_clear_pin_n;
  logic        boot_mode_pin;
  logic [4:0]  irq_pin;
  logic [7:0]  wake_pin_n;
  logic [19:0] periph_req;
  logic        core_boundary;
  logic        core_mask_set;
  logic        core_mask_clr;
  logic        cpu_hold;
  logic        periph_rst_n;
  logic        cond_imask;
  logic        pc_load;
  logic [15:0] pc_value;
  logic        int_ack;
  logic [4:0]  int_vec;
  logic        vec_rd;
  logic [15:0] vec_addr;
  logic [7:0]  vec_rdata;
  int          fails;
  int          checked;
  int          acks;
  int          bnd_cnt;
  int          cycles;

  rvp_top #(.MODE_WAIT(MW)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_clear_pin_n(chip_clear_pin_n), .boot_mode_pin(boot_mode_pin), .irq_pin(irq_pin),
    .wake_pin_n(wake_pin_n), .periph_req(periph_req), .core_boundary(core_boundary),
    .core_mask_set(core_mask_set), .core_mask_clr(core_mask_clr), .cpu_hold(cpu_hold),
    .periph_rst_n(periph_rst_n), .cond_imask(cond_imask), .pc_load(pc_load),
    .pc_value(pc_value), .int_ack(int_ack), .int_vec(int_vec), .vec_rd(vec_rd),
    .vec_addr(vec_addr), .vec_rdata(vec_rdata)
  );

  rvp_core_model core (
    .pclk(pclk), .presetn(presetn), .cpu_hold(cpu_hold), .pc_load(pc_load),
    .core_boundary(core_boundary), .vec_rd(vec_rd), .vec_addr(vec_addr),
    .vec_rdata(vec_rdata)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_pc(input int v);
    logic [7:0] a;
    a = 8'(2 * v);
    return {a ^ 8'hA5, (a + 8'h01) ^ 8'hA5};
  endfunction

  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b1, a, d, rd, err);
  endtask

  task automatic read_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b0, a, 32'h0, rd, err);
    check(what, rd, exp);
    check("pslverr", err, exp_err);
  endtask

  task automatic take_irq(input int v);
    int n;
    n = 0;
    @(posedge pclk);
    core_mask_clr <= 1'b1;
    @(posedge pclk);
    core_mask_clr <= 1'b0;
    do begin
      @(posedge pclk);
    end while (int_ack !== 1'b1);
    check("int_vec", int_vec, v);
    check("vec_addr", vec_addr, 2 * v);
    check("vec_rd", vec_rd, 1'b1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pc_load !== 1'b1 && n < 10);
    check("pc_load", pc_load, 1'b1);
    check("pc_value", pc_value, exp_pc(v));
  endtask

  // accepts only after an instruction end; reserved vector bytes never read
  always @(posedge pclk) begin
    cycles++;
    if (pc_load === 1'b1) begin
      bnd_cnt <= 0;
    end else if (core_boundary === 1'b1) begin
      bnd_cnt <= bnd_cnt + 1;
    end
    if (int_ack === 1'b1) begin
      acks++;
      check("boundary before accept", bnd_cnt != 0, 1);
    end
    if (vec_rd === 1'b1) begin
      check("reserved fetch", vec_addr >= 2 && vec_addr <= 7, 0);
    end
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic test_boot;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pc_load !== 1'b1 && n < 100);
    check("reset pc", pc_value, exp_pc(0));
    check("imask after reset", cond_imask, 1'b1);
    check("periph_rst_n", periph_rst_n, 1'b1);
    repeat (2) @(posedge pclk);
    check("cpu_hold", cpu_hold, 1'b0);
    read_chk("edge_sel", rvp_pkg::REG_EDGE_SEL, 32'h0, 1'b0);
    read_chk("enable", rvp_pkg::REG_ENABLE, 32'h0, 1'b0);
    read_chk("flags", rvp_pkg::REG_FLAGS, 32'h0, 1'b0);
    read_chk("unmapped", 8'h10, 32'h0, 1'b1);
    periph_req <= 20'h80000;
    take_irq(20);
    periph_req <= 20'h00000;
    read_chk("status", rvp_pkg::REG_STATUS, 32'h0000028E, 1'b0);
    $display("test boot done");
  endtask

  task automatic test_internal;
    int v;
    for (int b = 0; b < 20; b++) begin
      v = (b < 4) ? 10 + b : (b < 12) ? 14 + (b - 4) / 2 : (b < 18) ? 18 : b + 1;
      periph_req <= 20'hFFFFF << b;
      take_irq(v);
    end
    periph_req <= 20'h00000;
    $display("test internal done");
  endtask

  task automatic test_external;
    int a0;
    apb_write(rvp_pkg::REG_ENABLE, 32'h1FFF);
    @(posedge pclk);
    core_mask_set <= 1'b1;
    core_mask_clr <= 1'b1;
    @(posedge pclk);
    core_mask_set <= 1'b0;
    core_mask_clr <= 1'b0;
    a0 = acks;
    irq_pin[4]    <= 1'b0;
    wake_pin_n[0] <= 1'b0;
    periph_req    <= 20'h00001;
    repeat (12) @(posedge pclk);
    check("imask", cond_imask, 1'b1);
    check("accepts while masked", acks - a0, 0);
    read_chk("flags masked", rvp_pkg::REG_FLAGS, 32'h30, 1'b0);
    take_irq(8);
    apb_write(rvp_pkg::REG_FLAGS, 32'h10);
    take_irq(9);
    apb_write(rvp_pkg::REG_FLAGS, 32'h20);
    take_irq(10);
    periph_req <= 20'h00000;
    apb_write(rvp_pkg::REG_EDGE_SEL, 32'h04);
    read_chk("edge_sel", rvp_pkg::REG_EDGE_SEL, 32'h04, 1'b0);
    irq_pin[2] <= 1'b0;
    irq_pin[4] <= 1'b1;
    repeat (6) @(posedge pclk);
    read_chk("wrong edges", rvp_pkg::REG_FLAGS, 32'h0, 1'b0);
    irq_pin[2] <= 1'b1;
    repeat (6) @(posedge pclk);
    read_chk("rising edge", rvp_pkg::REG_FLAGS, 32'h04, 1'b0);
    take_irq(6);
    apb_write(rvp_pkg::REG_FLAGS, 32'h04);
    irq_pin[0]    <= 1'b0;
    wake_pin_n[7] <= 1'b0;
    take_irq(4);
    apb_write(rvp_pkg::REG_FLAGS, 32'h01);
    take_irq(9);
    apb_write(rvp_pkg::REG_FLAGS, 32'h1000);
    $display("test external done");
  endtask

  task automatic test_clear;
    int n;
    @(posedge pclk);
    chip_clear_pin_n <= 1'b0;
    boot_mode_pin    <= 1'b0;
    repeat (4) @(posedge pclk);
    check("hold on clear", cpu_hold, 1'b1);
    check("periph reset", periph_rst_n, 1'b0);
    check("imask on clear", cond_imask, 1'b1);
    read_chk("enable cleared", rvp_pkg::REG_ENABLE, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    chip_clear_pin_n <= 1'b1;
    repeat (40) @(posedge pclk);
    check("hold with mode low", cpu_hold, 1'b1);
    boot_mode_pin <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pc_load !== 1'b1 && n < MW + 40);
    check("mode wait", n >= MW && n <= MW + 10, 1);
    check("reset pc", pc_value, exp_pc(0));
    $display("test clear done");
  endtask

  initial begin
    fails = 0;
    checked = 0;
    acks = 0;
    bnd_cnt = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chip_clear_pin_n = 1'b0;
    boot_mode_pin = 1'b1;
    irq_pin = 5'h1F;
    wake_pin_n = 8'hFF;
    periph_req = 20'h00000;
    core_mask_set = 1'b0;
    core_mask_clr = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chip_clear_pin_n <= 1'b1;
    test_boot();
    test_internal();
    test_external();
    test_clear();
    give_verdict();
  end

endmodule // rvp_top_tb
